/* boot_id_defines.svh */
// register offsets, field positions, reset values and counts for the boot
// status and identification block; definitions only
`ifndef BOOT_ID_DEFINES_SVH
`define BOOT_ID_DEFINES_SVH

`define ADDR_W             16
`define DATA_W             32
`define OFS_PART_ID        16'h0000
`define OFS_REVISION       16'h0004
`define OFS_SOFT_RESET     16'h0020
`define OFS_BOOT_STATUS    16'h0028
`define OFS_BOOT_EVENT     16'h002c
`define OFS_PAD_CTRL       16'h0030
`define OFS_FW_BANK_EN     16'h0038
`define OFS_FW_BASE        16'h1000
`define FW_WINDOW_MSB      15
`define FW_WINDOW_LSB      9
`define FW_WINDOW_VAL      7'h08
`define BOOT_FLAG_BIT      3
`define PART_ID_MSB        23
`define REV_FULL_MSB       7
`define REV_FULL_LSB       4
`define REV_METAL_MSB      3
`define REV_METAL_LSB      0
`define SOFT_RESET_MSB     31
`define SOFT_RESET_LSB     24
`define SOFT_RESET_KEY     8'h5a
`define PAD_W              8
`define PAD_OUT_RST        8'h00
`define PAD_OE_RST         8'h00
`define PAD_OE_LSB         8
`define FW_BANKS           2
`define FW_BANK_EN_RST     2'h0
`define FW_WORDS_PER_BANK  64
`define FW_AW              7
`define TRIM_WORDS         4
`define TRIM_W             16
`define TRIM_CNT_W         3

`endif

/* boot_id_pkg.sv */
// types shared by the boot status and identification block
// assumes boot_id_defines.svh sits beside it
`include "boot_id_defines.svh"

package boot_id_pkg;
	// boot sequencer states
	typedef enum logic [0:0] {
		ST_LOADING,
		ST_DONE
	} boot_state_e;

	typedef logic [`ADDR_W-1:0] addr_t; // register address
	typedef logic [`DATA_W-1:0] data_t; // register data
endpackage

/* fw_mem.sv */
// firmware memory: banked single-port storage with a registered read port
// assumes the caller gates access by bank enable; no reset on the array
`timescale 1ns/1ps
`include "boot_id_defines.svh"

module fw_mem (
	input  wire logic                core_clk, // core clock
	input  wire logic                wr_en,    // write strobe
	input  wire logic                rd_en,    // read strobe
	input  wire logic [`FW_AW-1:0]   addr,     // bank and word index
	input  wire logic [`DATA_W-1:0]  wdata,    // write data
	output logic      [`DATA_W-1:0]  rdata     // registered read data
);
	// storage deliberately has no reset: contents are left as they are
	logic [`DATA_W-1:0] mem [0:`FW_BANKS*`FW_WORDS_PER_BANK-1]; // array

	// write port and registered read, both on the core clock
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[addr] <= wdata;
		end
		if (rd_en) begin
			rdata <= mem[addr];
		end
	end
endmodule

/* boot_id_core.sv */
// boot sequencer, boot status, soft reset, pad defaults and identification
// Summary of operation
// - boot loads trim after every reset kind
// - status bit 3 reads 0 busy, 1 done
// - boot completion drives irq pin low
// - pads return to defaults on any reset
// - hard resets never clear firmware memory
// - enabled firmware banks survive soft reset
// - address 0x0000 returns 24-bit part identifier
// - address 0x0004 returns full and metal revisions
// - writing 0x5a at 0x0020 soft resets
// - hardware reset pin holds registers at default, except the trim registers
// assumes a single core clock; hw_reset_pin_n comes straight from a pin
`timescale 1ns/1ps
`include "boot_id_defines.svh"

module boot_id_core #(
	parameter logic [23:0] PART_ID  = 24'h00a5c3, // arbitrary value
	parameter logic [3:0]  REV_FULL  = 4'h0,      // full-layer revision
	parameter logic [3:0]  REV_METAL = 4'h0       // metal-layer revision
) (
	input  wire logic                       core_clk,       // core clock
	input  wire logic                       reset_n,        // power-on reset
	input  wire logic                       hw_reset_pin_n, // reset pin
	input  wire logic                       reg_wr,         // write strobe
	input  wire logic                       reg_rd,         // read strobe
	input  wire boot_id_pkg::addr_t         reg_addr,       // byte address
	input  wire boot_id_pkg::data_t         reg_wdata,      // write data
	output boot_id_pkg::data_t              reg_rdata,      // read data
	output logic                            reg_rd_valid,   // read answer
	output logic                            irq_n,          // interrupt pin
	output logic                            boot_complete_flag, // boot done
	output logic [`TRIM_WORDS*`TRIM_W-1:0]  trim_values,    // loaded trim
	output logic [`PAD_W-1:0]               pad_out,        // pad levels
	output logic [`PAD_W-1:0]               pad_oe          // pad enables
);
	import boot_id_pkg::*;

	// factory trim table, fixed in silicon
	function automatic logic [`TRIM_W-1:0] trim_rom(
		input logic [`TRIM_CNT_W-1:0] idx
	);
		case (idx)
			3'h0:    trim_rom = 16'h1234;
			3'h1:    trim_rom = 16'h5678;
			3'h2:    trim_rom = 16'h9abc;
			default: trim_rom = 16'hdef0;
		endcase
	endfunction

	// true when an address falls in the firmware memory window
	function automatic logic is_fw(input addr_t a);
		is_fw = (a[`FW_WINDOW_MSB:`FW_WINDOW_LSB] == `FW_WINDOW_VAL);
	endfunction

	// reset pin synchroniser and agreement filter
	logic pin_s1_q, pin_s2_q, pin_s3_q; // synchroniser stages
	logic hw_rst_q, hw_rst_d;           // filtered pin reset, high = in reset

	// first stage is read only by the second; stages rest at the pin's
	// idle high level so power-on is not mistaken for a pin reset
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
			pin_s3_q <= 1'b1;
			hw_rst_q <= 1'b0;
		end else begin
			pin_s1_q <= hw_reset_pin_n;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			hw_rst_q <= hw_rst_d;
		end
	end

	// a change counts once stages two and three agree
	always_comb begin
		hw_rst_d = hw_rst_q;
		if (!pin_s2_q && !pin_s3_q) begin
			hw_rst_d = 1'b1;
		end else if (pin_s2_q && pin_s3_q) begin
			hw_rst_d = 1'b0;
		end
	end

	// soft reset request and combined control reset
	logic soft_hit;                // key written this cycle
	logic soft_rst_q;              // soft reset pulse, one cycle
	logic ctl_rst;                 // any reset besides power-on

	assign soft_hit = reg_wr && (reg_addr == `OFS_SOFT_RESET) &&
		(reg_wdata[`SOFT_RESET_MSB:`SOFT_RESET_LSB] == `SOFT_RESET_KEY);
	assign ctl_rst = hw_rst_q || soft_rst_q;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= soft_hit;
		end
	end

	// boot sequencer state
	boot_state_e              state_q, state_d;       // sequencer state
	logic [`TRIM_CNT_W-1:0]   cnt_q, cnt_d;           // trim word index
	logic [`TRIM_W-1:0]       trim_q [`TRIM_WORDS];   // trim registers
	logic [`TRIM_W-1:0]       trim_d [`TRIM_WORDS];
	logic                     flag_q, flag_d;         // boot complete flag
	logic                     evt_q, evt_d;           // pending boot event
	logic                     wr_evt_clr;             // write-one-clear hit

	assign wr_evt_clr = reg_wr && !soft_hit &&
		(reg_addr == `OFS_BOOT_EVENT) && reg_wdata[`BOOT_FLAG_BIT];

	// next boot values; any reset restarts the load from word zero
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		trim_d  = trim_q;
		flag_d  = flag_q;
		evt_d   = evt_q;
		if (wr_evt_clr) begin
			evt_d = 1'b0;
		end
		if (ctl_rst) begin
			state_d = ST_LOADING;
			cnt_d   = '0;
			flag_d  = 1'b0;
			evt_d   = 1'b0;
		end else begin
			case (state_q)
				ST_LOADING: begin
					trim_d[cnt_q[1:0]] = trim_rom(cnt_q);
					if (cnt_q == 3'(`TRIM_WORDS - 1)) begin
						state_d = ST_DONE;
						flag_d  = 1'b1;
						evt_d   = 1'b1;
					end else begin
						cnt_d = cnt_q + 3'd1;
					end
				end
				default: begin
					// idle until the next reset
				end
			endcase
		end
	end

	// boot registers; power-on also restarts the load
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_LOADING;
			cnt_q   <= '0;
			flag_q  <= 1'b0;
			evt_q   <= 1'b0;
			for (int i = 0; i < `TRIM_WORDS; i++) begin
				trim_q[i] <= '0;
			end
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			flag_q  <= flag_d;
			evt_q   <= evt_d;
			trim_q  <= trim_d;
		end
	end

	// pad control and firmware bank enables
	logic [`PAD_W-1:0]    pad_out_q, pad_out_d; // pad output levels
	logic [`PAD_W-1:0]    pad_oe_q, pad_oe_d;   // pad output enables
	logic [`FW_BANKS-1:0] bank_en_q, bank_en_d; // firmware bank enables

	// bank enables ignore soft reset so enabled banks stay usable
	always_comb begin
		pad_out_d = pad_out_q;
		pad_oe_d  = pad_oe_q;
		bank_en_d = bank_en_q;
		if (reg_wr && !soft_hit && reg_addr == `OFS_PAD_CTRL) begin
			pad_out_d = reg_wdata[`PAD_W-1:0];
			pad_oe_d  = reg_wdata[`PAD_OE_LSB+`PAD_W-1:`PAD_OE_LSB];
		end else if (reg_wr && reg_addr == `OFS_FW_BANK_EN) begin
			bank_en_d = reg_wdata[`FW_BANKS-1:0];
		end
		if (ctl_rst) begin
			pad_out_d = `PAD_OUT_RST;
			pad_oe_d  = `PAD_OE_RST;
		end
		if (hw_rst_q) begin
			bank_en_d = `FW_BANK_EN_RST;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pad_out_q <= `PAD_OUT_RST;
			pad_oe_q  <= `PAD_OE_RST;
			bank_en_q <= `FW_BANK_EN_RST;
		end else begin
			pad_out_q <= pad_out_d;
			pad_oe_q  <= pad_oe_d;
			bank_en_q <= bank_en_d;
		end
	end

	// firmware memory access, gated by the bank enable
	logic               fw_hit;   // access to an enabled bank
	logic [`FW_AW-1:0]  fw_addr;  // bank and word index
	data_t              fw_rdata; // registered memory read data

	assign fw_addr = reg_addr[`FW_AW+1:2];
	assign fw_hit  = is_fw(reg_addr) && bank_en_q[fw_addr[`FW_AW-1]];

	fw_mem u_fw_mem (
		.core_clk (core_clk),
		.wr_en    (reg_wr && fw_hit),
		.rd_en    (reg_rd && fw_hit),
		.addr     (fw_addr),
		.wdata    (reg_wdata),
		.rdata    (fw_rdata)
	);

	// register read decode; unmapped and write-only offsets read zero
	data_t rdata_q, rdata_d; // register read data
	logic  valid_q;          // read answer strobe
	logic  sel_fw_q;         // answer comes from firmware memory

	always_comb begin
		rdata_d = '0;
		if (reg_addr == `OFS_PART_ID) begin
			rdata_d[`PART_ID_MSB:0] = PART_ID;
		end else if (reg_addr == `OFS_REVISION) begin
			rdata_d[`REV_FULL_MSB:`REV_FULL_LSB]   = REV_FULL;
			rdata_d[`REV_METAL_MSB:`REV_METAL_LSB] = REV_METAL;
		end else if (reg_addr == `OFS_BOOT_STATUS) begin
			rdata_d[`BOOT_FLAG_BIT] = flag_q;
		end else if (reg_addr == `OFS_BOOT_EVENT) begin
			rdata_d[`BOOT_FLAG_BIT] = evt_q;
		end else if (reg_addr == `OFS_PAD_CTRL) begin
			rdata_d[`PAD_W-1:0] = pad_out_q;
			rdata_d[`PAD_OE_LSB+`PAD_W-1:`PAD_OE_LSB] = pad_oe_q;
		end else if (reg_addr == `OFS_FW_BANK_EN) begin
			rdata_d[`FW_BANKS-1:0] = bank_en_q;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q  <= '0;
			valid_q  <= 1'b0;
			sel_fw_q <= 1'b0;
		end else begin
			if (reg_rd) begin
				rdata_q <= rdata_d;
			end
			valid_q  <= reg_rd;
			sel_fw_q <= reg_rd && fw_hit;
		end
	end

	// outputs; disabled banks answer zero through the register path
	assign reg_rdata          = sel_fw_q ? fw_rdata : rdata_q;
	assign reg_rd_valid       = valid_q;
	assign boot_complete_flag = flag_q;
	assign irq_n              = !evt_q;
	assign pad_out            = pad_out_q;
	assign pad_oe             = pad_oe_q;
	for (genvar g = 0; g < `TRIM_WORDS; g++) begin : g_trim
		assign trim_values[g*`TRIM_W +: `TRIM_W] = trim_q[g];
	end
endmodule

/* boot_id_core_asserts.sv */
// port checker for the boot status and identification block
// assumes it is bound onto boot_id_core, one core clock domain
`timescale 1ns/1ps
module boot_id_core_asserts #(
	parameter logic [23:0] PART_ID   = 24'h00a5c3, // arbitrary value
	parameter logic [3:0]  REV_FULL  = 4'h0,       // full-layer rev
	parameter logic [3:0]  REV_METAL = 4'h0        // metal-layer rev
) (
	input wire logic               core_clk,           // core clock
	input wire logic               reset_n,            // power-on reset
	input wire logic               hw_reset_pin_n,     // reset pin
	input wire logic               reg_wr,             // write strobe
	input wire logic               reg_rd,             // read strobe
	input wire boot_id_pkg::addr_t reg_addr,           // byte address
	input wire boot_id_pkg::data_t reg_wdata,          // write data
	input wire boot_id_pkg::data_t reg_rdata,          // read data
	input wire logic               reg_rd_valid,       // read answer
	input wire logic               irq_n,              // interrupt pin
	input wire logic               boot_complete_flag, // boot done
	input wire logic [63:0]        trim_values,        // loaded trim
	input wire logic [7:0]         pad_out,            // pad levels
	input wire logic [7:0]         pad_oe              // pad enables
);
	import boot_id_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// key written into the reset field
	sequence s_soft;
		reg_wr && reg_addr == 16'h0020 && reg_wdata[31:24] == 8'h5a;
	endsequence
	// trim load: flag low four cycles, then up
	sequence s_boot;
		!boot_complete_flag [*4] ##1 boot_complete_flag;
	endsequence
	property p_soft_boot;
		s_soft |-> ##2 s_boot;
	endproperty
	a_soft_boot: assert property (p_soft_boot)
		else $error("soft reset boot timing wrong");
	property p_pad_soft;
		s_soft |-> ##2 pad_out == 8'h00 && pad_oe == 8'h00;
	endproperty
	a_pad_soft: assert property (p_pad_soft)
		else $error("pads not default after soft reset");
	// pin filter needs a few edges, so six low samples
	property p_hw_hold;
		!hw_reset_pin_n [*6] |-> !boot_complete_flag && pad_oe == 8'h00;
	endproperty
	a_hw_hold: assert property (p_hw_hold)
		else $error("state not default under reset pin");
	property p_irq_fall;
		$rose(boot_complete_flag) |-> $fell(irq_n);
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("no irq edge at boot done");
	property p_trim;
		$rose(boot_complete_flag) |-> trim_values == 64'hdef09abc56781234;
	endproperty
	a_trim: assert property (p_trim)
		else $error("trim not loaded at boot done");
	property p_id;
		reg_rd && reg_addr == 16'h0000 |=>
			reg_rd_valid && reg_rdata == {8'h00, PART_ID};
	endproperty
	a_id: assert property (p_id)
		else $error("part identifier read wrong");
	property p_rev;
		reg_rd && reg_addr == 16'h0004 |=>
			reg_rd_valid && reg_rdata == {24'h0, REV_FULL, REV_METAL};
	endproperty
	a_rev: assert property (p_rev)
		else $error("revision read wrong");
	property p_status;
		reg_rd && reg_addr == 16'h0028 |=>
			reg_rdata[3] == $past(boot_complete_flag);
	endproperty
	a_status: assert property (p_status)
		else $error("status bit differs from flag");
endmodule

bind boot_id_core boot_id_core_asserts #(.PART_ID(PART_ID),
	.REV_FULL(REV_FULL), .REV_METAL(REV_METAL)) u_chk (.core_clk,
	.reset_n, .hw_reset_pin_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
	.reg_rdata, .reg_rd_valid, .irq_n, .boot_complete_flag, .trim_values,
	.pad_out, .pad_oe);

/* host_model.sv */
// host model: register port master, one strobe per access
// assumes the block samples strobes on the rising core clock
`timescale 1ns/1ps
module host_model (
	input  wire logic               core_clk, // core clock
	input  wire logic               flag,     // boot done
	input  wire boot_id_pkg::data_t rdata,    // read data
	input  wire logic               rvalid,   // read answer
	output logic                    wr,       // write strobe
	output logic                    rd,       // read strobe
	output boot_id_pkg::addr_t      addr,     // byte address
	output boot_id_pkg::data_t      wdata     // write data
);
	import boot_id_pkg::*;
	// idle bus values
	initial begin
		wr = 1'b0;
		rd = 1'b0;
		addr = 16'h0000;
		wdata = 32'h0;
	end
	// writes hold off until boot done; lines scrambled after
	task automatic wr_reg(input addr_t a, input data_t d);
		for (int i = 0; i < 32 && flag !== 1'b1; i++)
			@(negedge core_clk);
		@(negedge core_clk);
		wr = 1'b1;
		addr = a;
		wdata = d;
		@(negedge core_clk);
		wr = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
	// read: answer lands one edge after the strobe
	task automatic rd_reg(input addr_t a, output data_t d);
		@(negedge core_clk);
		rd = 1'b1;
		addr = a;
		@(negedge core_clk);
		rd = 1'b0;
		addr = ~a;
		d = (rvalid === 1'b1) ? rdata : 'x;
	endtask
endmodule

/* test_boot_status_and_device_id.sv */
// testbench for boot status, soft reset, pads and identification
// assumes host_model and the bound checker are compiled first
`timescale 1ns/1ps
module test_boot_status_and_device_id;
	import boot_id_pkg::*;
	localparam logic [23:0] PID = 24'h3c5a69; // arbitrary value
	localparam logic [63:0] TRIM = 64'hdef09abc56781234; // trim table
	logic core_clk, reset_n, hw_n, wr, rd, rv, irq_n, flag; // dut pins
	addr_t addr;          // register address
	data_t wd, rdat, v;   // write, read, captured data
	logic [63:0] trim;    // loaded trim
	logic [7:0] po, poe;  // pad levels and enables
	int miscompares, checked, cyc; // counters
	boot_id_core #(.PART_ID(PID), .REV_FULL(4'h2), .REV_METAL(4'h7)) u_dut (
		.core_clk(core_clk), .reset_n(reset_n), .hw_reset_pin_n(hw_n),
		.reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd),
		.reg_rdata(rdat), .reg_rd_valid(rv), .irq_n(irq_n),
		.boot_complete_flag(flag), .trim_values(trim), .pad_out(po),
		.pad_oe(poe));
	host_model u_host (.core_clk(core_clk), .flag(flag), .rdata(rdat),
		.rvalid(rv), .wr(wr), .rd(rd), .addr(addr), .wdata(wd));
	// 125 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// bounded wait for boot done
	task wait_boot;
		for (int i = 0; i < 20 && flag !== 1'b1; i++)
			@(negedge core_clk);
	endtask
	// hang guard, run needs under a hundred cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			print_verdict;
		end
	end
	initial begin
		reset_n = 1'b0;
		hw_n = 1'b1;
		repeat (5) @(negedge core_clk);
		reset_n = 1'b1;
		repeat (3) @(negedge core_clk);
		check(flag, 0);
		@(negedge core_clk);
		check({flag, irq_n}, 2'b10);
		check(trim, TRIM);
		u_host.rd_reg(16'h0000, v);
		check(v, {8'h00, PID});
		u_host.rd_reg(16'h0004, v);
		check(v, 32'h27);
		u_host.rd_reg(16'h0028, v);
		check(v[3], 1);
		u_host.wr_reg(16'h002c, 32'h8);
		@(negedge core_clk);
		check(irq_n, 1);
		u_host.wr_reg(16'h0030, 32'ha55a);
		u_host.wr_reg(16'h0038, 32'h1);
		u_host.wr_reg(16'h1000, 32'hc0ffee11);
		u_host.wr_reg(16'h0020, 32'h5b000000);
		check({po, poe, flag}, {16'h5aa5, 1'b1});
		u_host.wr_reg(16'h0020, 32'h5a000000);
		@(negedge core_clk);
		check({po, poe, flag}, 0);
		wait_boot;
		check({flag, irq_n}, 2'b10);
		check(trim, TRIM);
		u_host.rd_reg(16'h1000, v);
		check(v, 32'hc0ffee11);
		u_host.rd_reg(16'h1100, v);
		check(v, 0);
		u_host.wr_reg(16'h0030, 32'hff00);
		hw_n = 1'b0;
		repeat (6) @(negedge core_clk);
		check({po, poe, flag}, 0);
		u_host.rd_reg(16'h0000, v);
		check(v, {8'h00, PID});
		hw_n = 1'b1;
		wait_boot;
		check({flag, irq_n}, 2'b10);
		check(trim, TRIM);
		u_host.rd_reg(16'h0038, v);
		check(v, 0);
		print_verdict;
	end
endmodule
